//--- bpcw_defs.svh
// constants for the bidirectional port with change wake block
`ifndef BPCW_DEFS_SVH
`define BPCW_DEFS_SVH
`define BPCW_ADDR_PORT_A_DATA 8'h05
`define BPCW_ADDR_PORT_B_DATA 8'h06
`define BPCW_ADDR_INTCTL 8'h0b
`define BPCW_ADDR_CMP 8'h1f
`define BPCW_ADDR_OPTION 8'h81
`define BPCW_ADDR_PORT_A_DIRECTION 8'h85
`define BPCW_ADDR_PORT_B_DIRECTION 8'h86
`define BPCW_ADDR_VREF 8'h9f
`define BPCW_RST_OPTION 8'hff
`define BPCW_RST_PORT_A_DIRECTION 5'h1f
`define BPCW_RST_PORT_B_DIRECTION 8'hff
`define BPCW_RST_CMP 4'h0
`define BPCW_RST_VREF 7'h00
`define BPCW_RST_LATCH_A 5'h00
`define BPCW_RST_LATCH_B 8'h00
`define BPCW_POS_PULLUP_N 7
`define BPCW_POS_CHG_FLAG 0
`define BPCW_POS_CHG_WAKE_EN 3
`define BPCW_OD_PIN 4
`endif

//--- bpcw_pkg.sv
// types shared by the bidirectional port with change wake block
package bpcw_pkg;
    typedef logic [7:0] bpcw_byte_t;
    typedef logic [4:0] bpcw_port_a_data_t;
    typedef logic [3:0] bpcw_nib_t;
    typedef enum logic [1:0] {
        BPCW_OP_NONE = 2'b00,
        BPCW_OP_WRITE = 2'b01,
        BPCW_OP_BSET = 2'b10,
        BPCW_OP_BCLR = 2'b11
    } bpcw_op_e;
endpackage : bpcw_pkg

//--- bpcw_gpio.sv
// port a and port b pin logic with change detection and register file
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "bpcw_defs.svh"
module bpcw_gpio (
    input wire logic i_mclk, // 250 MHz core clock
    input wire logic i_rstn, // async reset, active low
    input wire logic i_ce, // clock enable, freezes all state
    input wire bpcw_pkg::bpcw_byte_t i_addr, // register address
    input wire bpcw_pkg::bpcw_byte_t i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    input wire logic i_bit_set, // single-bit set on a port
    input wire logic i_bit_clr, // single-bit clear on a port
    input wire logic [2:0] i_bit_sel, // bit number for set or clear
    output bpcw_pkg::bpcw_byte_t o_rdata, // read data, cycle after read
    input wire bpcw_pkg::bpcw_byte_t i_pb_in, // port b pin levels
    output bpcw_pkg::bpcw_byte_t o_pb_out, // port b output latch
    output bpcw_pkg::bpcw_byte_t o_pb_oe, // port b driver enable
    output bpcw_pkg::bpcw_byte_t o_pb_pullup, // port b weak pull-up on
    output bpcw_pkg::bpcw_byte_t o_pb_schmitt, // port b schmitt buffer select
    input wire bpcw_pkg::bpcw_port_a_data_t i_pa_in, // port a pin levels
    output bpcw_pkg::bpcw_port_a_data_t o_pa_out, // port a output value
    output bpcw_pkg::bpcw_port_a_data_t o_pa_oe, // port a driver enable
    input wire logic [1:0] i_cmp_out, // comparator results
    input wire logic i_ext_int_en, // pin 0 used as external interrupt
    input wire logic i_prog_mode, // serial programming mode active
    output logic o_pin_change_flag, // change flag level
    output logic o_change_wake // wake request to core
);
    import bpcw_pkg::*;

    // pin synchronisers: three stages, accept when stages two and three agree
    logic [12:0] sync1;
    logic [12:0] sync2;
    logic [12:0] sync3;
    logic [12:0] pins_f;
    bpcw_byte_t pin_b;
    bpcw_port_a_data_t pin_a;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1 <= 13'h0000;
            sync2 <= 13'h0000;
            sync3 <= 13'h0000;
        end else if (i_ce) begin
            sync1 <= {i_pa_in, i_pb_in};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // per-bit filter; a lone glitch of one cycle never reaches the pins view
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            pins_f <= 13'h0000;
        end else if (i_ce) begin
            pins_f <= (sync2 & ~(sync2 ^ sync3)) | (pins_f & (sync2 ^ sync3));
        end
    end

    assign pin_b = pins_f[7:0];
    assign pin_a = pins_f[12:8];

    // register state
    bpcw_byte_t latch_b;
    bpcw_port_a_data_t latch_a;
    bpcw_byte_t dir_b;
    bpcw_port_a_data_t dir_a;
    bpcw_byte_t option;
    logic [3:0] cmp_ctl;
    logic [6:0] vref_ctl;
    bpcw_nib_t ref_b;
    logic chg_flag;
    logic chg_wake_en;
    bpcw_op_e op;
    bpcw_byte_t next_latch_b;
    bpcw_port_a_data_t next_latch_a;
    bpcw_byte_t bit_mask;
    logic sel_a;
    logic sel_b;
    logic acc_b;
    bpcw_nib_t mismatch;
    logic chg_clear;

    assign sel_a = (i_addr == `BPCW_ADDR_PORT_A_DATA);
    assign sel_b = (i_addr == `BPCW_ADDR_PORT_B_DATA);
    assign bit_mask = 8'h01 << i_bit_sel;

    always_comb begin
        if (i_wr) begin
            op = BPCW_OP_WRITE;
        end else if (i_bit_set) begin
            op = BPCW_OP_BSET;
        end else if (i_bit_clr) begin
            op = BPCW_OP_BCLR;
        end else begin
            op = BPCW_OP_NONE;
        end
    end

    // bit ops start from pin levels, so inputs overwrite their latch bits
    always_comb begin
        case (op)
            BPCW_OP_WRITE: begin
                next_latch_b = i_wdata;
                next_latch_a = i_wdata[4:0];
            end
            BPCW_OP_BSET: begin
                next_latch_b = pin_b | bit_mask;
                next_latch_a = pin_a | bit_mask[4:0];
            end
            BPCW_OP_BCLR: begin
                next_latch_b = pin_b & ~bit_mask;
                next_latch_a = pin_a & ~bit_mask[4:0];
            end
            default: begin
                next_latch_b = latch_b;
                next_latch_a = latch_a;
            end
        endcase
    end

    // latch takes the value at the edge ending the access cycle
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            latch_b <= `BPCW_RST_LATCH_B;
        end else if (i_ce && sel_b && op != BPCW_OP_NONE) begin
            latch_b <= next_latch_b;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            latch_a <= `BPCW_RST_LATCH_A;
        end else if (i_ce && sel_a && op != BPCW_OP_NONE) begin
            latch_a <= next_latch_a;
        end
    end

    // direction and option registers
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            dir_b <= `BPCW_RST_PORT_B_DIRECTION;
            dir_a <= `BPCW_RST_PORT_A_DIRECTION;
            option <= `BPCW_RST_OPTION;
        end else if (i_ce && i_wr) begin
            if (i_addr == `BPCW_ADDR_PORT_B_DIRECTION) begin
                dir_b <= i_wdata;
            end
            if (i_addr == `BPCW_ADDR_PORT_A_DIRECTION) begin
                dir_a <= i_wdata[4:0];
            end
            if (i_addr == `BPCW_ADDR_OPTION) begin
                option <= i_wdata;
            end
        end
    end

    // comparator and reference controls are only stored here
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmp_ctl <= `BPCW_RST_CMP;
            vref_ctl <= `BPCW_RST_VREF;
        end else if (i_ce && i_wr) begin
            if (i_addr == `BPCW_ADDR_CMP) begin
                cmp_ctl <= i_wdata[3:0];
            end
            if (i_addr == `BPCW_ADDR_VREF) begin
                vref_ctl <= {i_wdata[7:5], i_wdata[3:0]};
            end
        end
    end

    // change detection on upper four input pins
    assign acc_b = sel_b && (i_rd || op != BPCW_OP_NONE);
    assign mismatch = (pin_b[7:4] ^ ref_b) & dir_b[7:4];

    // reference sampled at the access edge; a pin differing from it on that
    // same edge still sets the flag through the mismatch seen there
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ref_b <= 4'h0;
        end else if (i_ce && acc_b) begin
            ref_b <= pin_b[7:4];
        end
    end

    assign chg_clear = i_wr && (i_addr == `BPCW_ADDR_INTCTL)
        && !i_wdata[`BPCW_POS_CHG_FLAG];

    // set beats clear, so the flag cannot be cleared while a mismatch holds
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            chg_flag <= 1'b0;
        end else if (i_ce) begin
            if (|mismatch) begin
                chg_flag <= 1'b1;
            end else if (chg_clear) begin
                chg_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            chg_wake_en <= 1'b0;
        end else if (i_ce && i_wr && i_addr == `BPCW_ADDR_INTCTL) begin
            chg_wake_en <= i_wdata[`BPCW_POS_CHG_WAKE_EN];
        end
    end

    // read data, sampled pins captured at the read edge
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            if (i_rd) begin
                case (i_addr)
                    `BPCW_ADDR_PORT_A_DATA: o_rdata <= {3'h0, pin_a};
                    `BPCW_ADDR_PORT_B_DATA: o_rdata <= pin_b;
                    `BPCW_ADDR_INTCTL: begin
                        o_rdata <= {4'h0, chg_wake_en, 2'h0, chg_flag};
                    end
                    `BPCW_ADDR_CMP: begin
                        o_rdata <= {i_cmp_out, 2'h0, cmp_ctl[3:0]};
                    end
                    `BPCW_ADDR_OPTION: o_rdata <= option;
                    `BPCW_ADDR_PORT_A_DIRECTION: o_rdata <= {3'h0, dir_a};
                    `BPCW_ADDR_PORT_B_DIRECTION: o_rdata <= dir_b;
                    `BPCW_ADDR_VREF: begin
                        o_rdata <= {vref_ctl[6:4], 1'h0, vref_ctl[3:0]};
                    end
                    default: o_rdata <= 8'h00;
                endcase
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end

    // pin drivers
    assign o_pb_out = latch_b;
    assign o_pb_oe = ~dir_b;
    assign o_pb_pullup = {8{~option[`BPCW_POS_PULLUP_N]}} & dir_b;
    assign o_pb_schmitt = {{2{i_prog_mode}}, 5'h00, i_ext_int_en};

    // open-drain pin pulls low only; a high latch lets it float
    always_comb begin
        o_pa_out = latch_a;
        o_pa_oe = ~dir_a;
        o_pa_out[`BPCW_OD_PIN] = 1'b0;
        o_pa_oe[`BPCW_OD_PIN] = ~dir_a[`BPCW_OD_PIN] & ~latch_a[`BPCW_OD_PIN];
    end

    assign o_pin_change_flag = chg_flag;
    assign o_change_wake = chg_flag & chg_wake_en;

    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    sequence port_b_bitset_s;
        i_ce && !i_wr && i_bit_set && sel_b;
    endsequence

    sequence port_b_access_s;
        i_ce && acc_b;
    endsequence

    pullup_vs_drive_a: assert property (
        !(|(o_pb_pullup & o_pb_oe)))
        else $error("pull-up on while pin driven");

    port_write_latch_a: assert property (
        i_ce && i_wr && sel_b |=> o_pb_out == $past(i_wdata))
        else $error("port write not in latch");

    port_read_pins_a: assert property (
        i_ce && i_rd && sel_b |=> o_rdata == $past(pin_b))
        else $error("port read not pin levels");

    bitop_pins_a: assert property (
        port_b_bitset_s |=> o_pb_out == ($past(pin_b) | $past(bit_mask)))
        else $error("bit set did not start from pins");

    ref_capture_a: assert property (
        port_b_access_s |=> ref_b == $past(pin_b[7:4]))
        else $error("reference not recaptured");

    mismatch_sets_a: assert property (
        i_ce && (|mismatch) |=> o_pin_change_flag)
        else $error("mismatch did not set flag");

    clear_blocked_a: assert property (
        i_ce && chg_clear && (|mismatch) |=> o_pin_change_flag [*1])
        else $error("flag cleared during mismatch");

    output_excluded_a: assert property (
        i_ce && !(|mismatch) && !o_pin_change_flag && !chg_clear
        |=> !o_pin_change_flag)
        else $error("flag set without input mismatch");

    wake_follows_a: assert property (
        o_pin_change_flag && chg_wake_en |-> o_change_wake)
        else $error("no wake on change");

    upper_zero_a: assert property (
        i_ce && i_rd && i_addr == `BPCW_ADDR_PORT_A_DIRECTION |=> o_rdata[7:5] == 3'h0)
        else $error("unimplemented bits not zero");

    freeze_a: assert property (
        !i_ce |=> $stable(o_pb_out) && $stable(o_pin_change_flag))
        else $error("state moved with enable low");

    sequence port_b_bitclr_s;
        i_ce && !i_wr && !i_bit_set && i_bit_clr && sel_b;
    endsequence

    dir_write_a: assert property (
        i_ce && i_wr && i_addr == `BPCW_ADDR_PORT_B_DIRECTION
        |=> o_pb_oe == ~$past(i_wdata))
        else $error("direction write not on drivers");

    port_a_data_write_a: assert property (
        i_ce && i_wr && sel_a |=> latch_a == $past(i_wdata[4:0]))
        else $error("port a write not in latch");

    port_a_data_read_a: assert property (
        i_ce && i_rd && sel_a |=> o_rdata[4:0] == $past(pin_a))
        else $error("port a read not pin levels");

    bitclr_pins_a: assert property (
        port_b_bitclr_s |=> o_pb_out == ($past(pin_b) & ~$past(bit_mask)))
        else $error("bit clear did not start from pins");

    pullup_on_a: assert property (
        !option[`BPCW_POS_PULLUP_N] |-> o_pb_pullup == dir_b)
        else $error("pull-ups not on for inputs");

    pullup_off_a: assert property (
        option[`BPCW_POS_PULLUP_N] |-> o_pb_pullup == 8'h00)
        else $error("pull-ups on while disabled");

    ref_hold_a: assert property (
        i_ce && !acc_b |=> $stable(ref_b))
        else $error("reference moved without access");

    clear_works_a: assert property (
        i_ce && chg_clear && !(|mismatch) |=> !o_pin_change_flag)
        else $error("flag clear lost without mismatch");

    rd_idle_a: assert property (
        i_ce && !i_rd |=> o_rdata == 8'h00)
        else $error("read data outside read cycle");

    port_a_data_zero_a: assert property (
        i_ce && i_rd && sel_a |=> o_rdata[7:5] == 3'h0)
        else $error("port a upper bits not zero");

    cmp_zero_a: assert property (
        i_ce && i_rd && i_addr == `BPCW_ADDR_CMP |=> o_rdata[5:4] == 2'h0)
        else $error("comparator spare bits not zero");

    vref_zero_a: assert property (
        i_ce && i_rd && i_addr == `BPCW_ADDR_VREF |=> !o_rdata[4])
        else $error("reference spare bit not zero");

    ttl_rest_a: assert property (
        o_pb_schmitt[5:1] == 5'h00)
        else $error("schmitt buffer on a plain pin");

    prog_schmitt_a: assert property (
        o_pb_schmitt[7:6] == {2{i_prog_mode}})
        else $error("programming pins buffer wrong");

    wake_off_a: assert property (
        !chg_wake_en |-> !o_change_wake)
        else $error("wake while wake disabled");

endmodule : bpcw_gpio

//--- bpcw_pins.sv
// board model of the port b pins: drivers, keypad and weak pull-ups
`timescale 1ns/1ps
module bpcw_pins (
    input wire logic i_mclk, // clock for the floating pattern
    input wire bpcw_pkg::bpcw_byte_t i_oe, // device drives pin
    input wire bpcw_pkg::bpcw_byte_t i_out, // device output latch
    input wire bpcw_pkg::bpcw_byte_t i_pu, // weak pull-up on
    input wire bpcw_pkg::bpcw_byte_t i_ext, // keypad level
    input wire bpcw_pkg::bpcw_byte_t i_ext_en, // keypad drives pin
    output bpcw_pkg::bpcw_byte_t o_pin // resolved wire level
);
    import bpcw_pkg::*;
    bpcw_byte_t flt;
    initial flt = 8'h55;
    // a floating line must not settle to a handy value
    always @(posedge i_mclk) begin
        flt <= ~flt;
    end
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
        | (~i_oe & ~i_ext_en & (i_pu | flt));
endmodule : bpcw_pins

//--- bpcw_gpio_tb.sv
// self-checking bench for the port logic with change wake
`timescale 1ns/1ps
`include "bpcw_defs.svh"
module bpcw_gpio_tb;
    import bpcw_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_ce = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_bit_set = 1'b0;
    logic i_bit_clr = 1'b0;
    logic [2:0] i_bit_sel = 3'h0;
    logic i_ext_int_en = 1'b0;
    logic i_prog_mode = 1'b0;
    bpcw_byte_t i_addr = 8'h00;
    bpcw_byte_t i_wdata = 8'h00;
    bpcw_byte_t ext = 8'h3c;
    bpcw_byte_t rdata, pb_out, pb_oe, pb_pu, pb_st, pb_in, d;
    bpcw_port_a_data_t pa_out, pa_oe, pa_in;
    logic flag, wake;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    bpcw_byte_t ra [6] = '{`BPCW_ADDR_PORT_B_DIRECTION, `BPCW_ADDR_OPTION,
        `BPCW_ADDR_PORT_A_DIRECTION, `BPCW_ADDR_CMP, `BPCW_ADDR_VREF, 8'h33};
    bpcw_byte_t re [6] = '{8'hff, 8'hff, 8'h1f, 8'h80, 8'h00, 8'h00};

    // released open-drain bit reads high through the board pull-up
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & 5'h15);

    bpcw_gpio dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_bit_set(i_bit_set), .i_bit_clr(i_bit_clr),
        .i_bit_sel(i_bit_sel), .o_rdata(rdata), .i_pb_in(pb_in),
        .o_pb_out(pb_out), .o_pb_oe(pb_oe), .o_pb_pullup(pb_pu),
        .o_pb_schmitt(pb_st), .i_pa_in(pa_in), .o_pa_out(pa_out),
        .o_pa_oe(pa_oe), .i_cmp_out(2'b10), .i_ext_int_en(i_ext_int_en),
        .i_prog_mode(i_prog_mode), .o_pin_change_flag(flag),
        .o_change_wake(wake));

    bpcw_pins pins_u (.i_mclk(i_mclk), .i_oe(pb_oe), .i_out(pb_out),
        .i_pu(pb_pu), .i_ext(ext), .i_ext_en(8'hff), .o_pin(pb_in));

    initial begin
        forever #2 i_mclk = ~i_mclk;
    end

    task automatic end_sim();
        $display("errors %0d, checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        // the whole sequence needs well under a thousand cycles
        if (cycles == 5000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic chk(input bpcw_byte_t g, input bpcw_byte_t e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : cyc

    task automatic wr(input bpcw_byte_t a, input bpcw_byte_t v);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input bpcw_byte_t a, output bpcw_byte_t v);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    task automatic bop(input logic s, input logic [2:0] b);
        @(posedge i_mclk);
        i_addr <= `BPCW_ADDR_PORT_B_DATA;
        i_bit_sel <= b;
        if (s) begin
            i_bit_set <= 1'b1;
        end else begin
            i_bit_clr <= 1'b1;
        end
        @(posedge i_mclk);
        i_bit_set <= 1'b0;
        i_bit_clr <= 1'b0;
    endtask : bop

    initial begin
        repeat (16) @(posedge i_mclk);
        i_rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], d);
            chk(d, re[i]);
        end
        wr(`BPCW_ADDR_CMP, 8'hff);
        wr(`BPCW_ADDR_VREF, 8'hff);
        rd(`BPCW_ADDR_CMP, d);
        chk(d, 8'h8f);
        rd(`BPCW_ADDR_VREF, d);
        chk(d, 8'hef);
        chk(pb_pu, 8'h00);
        wr(`BPCW_ADDR_PORT_B_DIRECTION, 8'h0f);
        wr(`BPCW_ADDR_PORT_B_DATA, 8'ha5);
        cyc(6);
        chk(pb_oe, 8'hf0);
        chk(pb_out, 8'ha5);
        rd(`BPCW_ADDR_PORT_B_DATA, d);
        chk(d, 8'hac);
        wr(`BPCW_ADDR_OPTION, 8'h7f);
        cyc(2);
        chk(pb_pu, 8'h0f);
        wr(`BPCW_ADDR_OPTION, 8'hff);
        cyc(2);
        chk(pb_pu, 8'h00);
        // upper inputs see keypad 3, lower outputs hold latch 5
        wr(`BPCW_ADDR_PORT_B_DIRECTION, 8'hf0);
        cyc(6);
        bop(1'b1, 3'h1);
        cyc(6);
        chk(pb_out, 8'h37);
        bop(1'b0, 3'h4);
        cyc(2);
        chk(pb_out, 8'h27);
        wr(`BPCW_ADDR_PORT_B_DIRECTION, 8'hff);
        cyc(6);
        rd(`BPCW_ADDR_PORT_B_DATA, d);
        chk(d, 8'h3c);
        wr(`BPCW_ADDR_INTCTL, 8'h00);
        cyc(2);
        chk({7'h0, flag}, 8'h01 & 8'h00);
        ext <= 8'h3d;
        cyc(8);
        chk({7'h0, flag}, 8'h00);
        ext <= 8'hbd;
        cyc(8);
        chk({7'h0, flag}, 8'h01);
        wr(`BPCW_ADDR_INTCTL, 8'h00);
        cyc(2);
        chk({7'h0, flag}, 8'h01);
        wr(`BPCW_ADDR_INTCTL, 8'h08);
        cyc(2);
        chk({7'h0, wake}, 8'h01);
        rd(`BPCW_ADDR_PORT_B_DATA, d);
        chk(d, 8'hbd);
        wr(`BPCW_ADDR_INTCTL, 8'h08);
        cyc(2);
        chk({6'h0, wake, flag}, 8'h00);
        rd(`BPCW_ADDR_INTCTL, d);
        chk(d, 8'h08);
        // pin 7 becomes an output driving 0 against the old reference
        wr(`BPCW_ADDR_PORT_B_DIRECTION, 8'h7f);
        cyc(8);
        chk({7'h0, flag}, 8'h00);
        // enable low: a write strobe must leave the latch alone
        @(posedge i_mclk);
        i_ce <= 1'b0;
        wr(`BPCW_ADDR_PORT_B_DATA, 8'h00);
        @(posedge i_mclk);
        i_ce <= 1'b1;
        cyc(2);
        chk(pb_out, 8'h27);
        @(posedge i_mclk);
        i_ext_int_en <= 1'b1;
        i_prog_mode <= 1'b1;
        cyc(2);
        chk(pb_st, 8'hc1);
        @(posedge i_mclk);
        i_ext_int_en <= 1'b0;
        i_prog_mode <= 1'b0;
        cyc(2);
        chk(pb_st, 8'h00);
        wr(`BPCW_ADDR_PORT_A_DIRECTION, 8'h00);
        wr(`BPCW_ADDR_PORT_A_DATA, 8'h1e);
        cyc(6);
        chk({3'h0, pa_out}, 8'h0e);
        chk({3'h0, pa_oe}, 8'h0f);
        rd(`BPCW_ADDR_PORT_A_DATA, d);
        chk(d, 8'h1e);
        end_sim();
    end
endmodule : bpcw_gpio_tb
